/* design/lcgc_fifo.v */
// synchronous valid/ready fifo with parameterised width and depth
`timescale 1ns/1ps
module lcgc_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clock,
  input  wire             reset_n,
  input  wire             clock_enable,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  // occupancy
  output wire [AW:0]      level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  // handshakes are frozen with the clock enable so nothing is lost
  assign in_ready  = clock_enable & (count != DEPTH[AW:0]);
  assign out_valid = clock_enable & (count != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];
  assign level     = count;

  // storage array, no reset needed on data
  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers wrap at DEPTH, which need not be a power of two
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

/* design/lcgc_gain.v */
// one channel multiplier: sample times 9-bit code over unity, rounded and clipped
`timescale 1ns/1ps
module lcgc_gain #(
  parameter [8:0] UNITY  = 9'h0D8,
  parameter       CHROMA = 0,
  parameter [7:0] LO     = 8'h00,
  parameter [7:0] HI     = 8'hFF
) (
  // operands
  input  wire [7:0] sample,
  input  wire [8:0] gain,
  // scaled sample
  output reg  [7:0] result
);

  reg signed [19:0] centred;
  reg signed [19:0] product;
  reg signed [19:0] rounded;
  reg signed [19:0] quotient;
  reg signed [19:0] shifted;

  // chroma is offset binary around 8'h80, so scale the difference only
  always @* begin
    if (CHROMA != 0) begin
      centred = $signed({12'h000, sample}) - 20'sh00080;
    end else begin
      centred = $signed({12'h000, sample});
    end
    product = centred * $signed({11'h000, gain});
    // symmetric rounding: division truncates toward zero
    if (product < 0) begin
      rounded = product - $signed({12'h000, UNITY[8:1]});
    end else begin
      rounded = product + $signed({12'h000, UNITY[8:1]});
    end
    quotient = rounded / $signed({11'h000, UNITY});
    shifted  = (CHROMA != 0) ? quotient + 20'sh00080 : quotient;
    // clip, never wrap
    if (shifted < $signed({12'h000, LO})) begin
      result = LO;
    end else if (shifted > $signed({12'h000, HI})) begin
      result = HI;
    end else begin
      result = shifted[7:0];
    end
  end

endmodule

/* design/lcgc_map.vh */
// register map, reset values and gain constants of the luma/chroma gain stage
`ifndef LCGC_MAP_VH
`define LCGC_MAP_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define LCGC_ADDR_CONTROL    8'h0B
`define LCGC_ADDR_LUMA_LOW   8'h0C
`define LCGC_ADDR_U_LOW      8'h0D
`define LCGC_ADDR_V_LOW      8'h0E
`define LCGC_ADDR_STATUS     8'h1F

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LCGC_RST_CONTROL     8'h20
`define LCGC_RST_LUMA_LOW    8'hD8
`define LCGC_RST_U_LOW       8'hFE
`define LCGC_RST_V_LOW       8'hB4

// ----------------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------------
`define LCGC_BIT_V_TOP       0
`define LCGC_BIT_U_TOP       1
`define LCGC_BIT_LUMA_TOP    2
`define LCGC_BIT_RESERVED    3

// ----------------------------------------------------------------------
// gain arithmetic, clipping and fifo depth
// ----------------------------------------------------------------------
`define LCGC_UNITY_LUMA      9'h0D8
`define LCGC_UNITY_U         9'h0FE
`define LCGC_UNITY_V         9'h0B4
`define LCGC_LUMA_MIN        8'h00
`define LCGC_LUMA_MAX        8'hFF
`define LCGC_CHROMA_MIN      8'h02
`define LCGC_CHROMA_MAX      8'hFD
`define LCGC_FIFO_DEPTH      16

`endif

/* design/lcgc_top.v */
// luma/chroma gain stage: gain registers, sample fifo and output multipliers
//
// Summary of operation
// - luma low byte rw, resets to D8
// - luma code is top bit over low byte
// - luma gain equals code over 216
// - u low byte rw, resets to FE
// - u gain code over 254, zero blanks
// - v low byte rw, resets to B4
// - v gain equals code over 180
// - control bits 2,1,0 hold luma,u,v top bits
`timescale 1ns/1ps
`include "lcgc_map.vh"

module lcgc_top #(
  parameter DEPTH = `LCGC_FIFO_DEPTH,
  parameter AW    = 4
) (
  // clock, reset and enable
  input  wire       clock,
  input  wire       reset_n,
  input  wire       clock_enable,
  // register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  // incoming samples
  input  wire       in_valid,
  output wire       in_ready,
  input  wire [7:0] in_luma,
  input  wire [7:0] in_u,
  input  wire [7:0] in_v,
  // scaled samples
  output reg        out_valid,
  input  wire       out_ready,
  output reg  [7:0] out_luma,
  output reg  [7:0] out_u,
  output reg  [7:0] out_v
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  localparam [26:0] UNITIES = {`LCGC_UNITY_V, `LCGC_UNITY_U, `LCGC_UNITY_LUMA};

  reg  [7:0]  luma_gain_low;
  reg  [7:0]  u_chroma_gain_low;
  reg  [7:0]  v_chroma_gain_low;
  reg  [7:0]  control;
  reg  [7:0]  next_rdata;
  wire        luma_gain_top_bit;
  wire        u_chroma_gain_top_bit;
  wire        v_chroma_gain_top_bit;
  wire [8:0]  luma_gain_value;
  wire [8:0]  u_chroma_gain_value;
  wire [8:0]  v_chroma_gain_value;
  wire [26:0] gains;
  wire [23:0] head_samples;
  wire [23:0] scaled;
  wire        head_valid;
  wire        head_ready;
  wire [AW:0] level;
  wire [7:0]  status;
  wire        write_hit;

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------

  // gain and control registers take a write whenever clock_enable is high; no write side effects
  assign write_hit = clock_enable & reg_write;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      luma_gain_low     <= `LCGC_RST_LUMA_LOW;
      u_chroma_gain_low <= `LCGC_RST_U_LOW;
      v_chroma_gain_low <= `LCGC_RST_V_LOW;
      control           <= `LCGC_RST_CONTROL;
    end else if (write_hit) begin
      case (reg_addr)
        `LCGC_ADDR_LUMA_LOW: begin
          luma_gain_low <= reg_wdata;
        end
        `LCGC_ADDR_U_LOW: begin
          u_chroma_gain_low <= reg_wdata;
        end
        `LCGC_ADDR_V_LOW: begin
          v_chroma_gain_low <= reg_wdata;
        end
        `LCGC_ADDR_CONTROL: begin
          // upper fields are kept so a read-modify-write round trips
          control <= reg_wdata;
          control[`LCGC_BIT_RESERVED] <= 1'b0;
        end
        default: begin
          control <= control;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // gain codes
  // ----------------------------------------------------------------------

  // top bits live in the shared control register
  assign luma_gain_top_bit     = control[`LCGC_BIT_LUMA_TOP];
  assign u_chroma_gain_top_bit = control[`LCGC_BIT_U_TOP];
  assign v_chroma_gain_top_bit = control[`LCGC_BIT_V_TOP];

  // nine-bit codes: top bit is bit 8, low byte below it
  assign luma_gain_value     = {luma_gain_top_bit, luma_gain_low};
  assign u_chroma_gain_value = {u_chroma_gain_top_bit, u_chroma_gain_low};
  assign v_chroma_gain_value = {v_chroma_gain_top_bit, v_chroma_gain_low};

  assign gains = {v_chroma_gain_value, u_chroma_gain_value, luma_gain_value};

  // ----------------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------------

  // status shows fifo occupancy and output stage state
  assign status = {out_valid, in_ready, 1'b0, level[AW:0]};

  // reserved control bit always reads back zero
  always @* begin
    case (reg_addr)
      `LCGC_ADDR_CONTROL: begin
        next_rdata = control;
      end
      `LCGC_ADDR_LUMA_LOW: begin
        next_rdata = luma_gain_low;
      end
      `LCGC_ADDR_U_LOW: begin
        next_rdata = u_chroma_gain_low;
      end
      `LCGC_ADDR_V_LOW: begin
        next_rdata = v_chroma_gain_low;
      end
      `LCGC_ADDR_STATUS: begin
        next_rdata = status;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe, zero otherwise; held while clock_enable is low
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (clock_enable) begin
      if (reg_read) begin
        reg_rdata <= next_rdata;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // sample buffer
  // ----------------------------------------------------------------------

  // the fifo absorbs bursts while the sink stalls; in_ready is its space
  lcgc_fifo #(
    .WIDTH (24),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .clock        (clock),
    .reset_n      (reset_n),
    .clock_enable (clock_enable),
    .in_valid     (in_valid),
    .in_ready     (in_ready),
    .in_data      ({in_v, in_u, in_luma}),
    .out_valid    (head_valid),
    .out_ready    (head_ready),
    .out_data     (head_samples),
    .level        (level)
  );

  // ----------------------------------------------------------------------
  // multipliers
  // ----------------------------------------------------------------------

  // channel 0 is luma, 1 is u, 2 is v; chroma clips to its narrower range
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
      lcgc_gain #(
        .UNITY  (UNITIES[9*ch+8:9*ch]),
        .CHROMA ((ch == 0) ? 0 : 1),
        .LO     ((ch == 0) ? `LCGC_LUMA_MIN : `LCGC_CHROMA_MIN),
        .HI     ((ch == 0) ? `LCGC_LUMA_MAX : `LCGC_CHROMA_MAX)
      ) u_gain (
        .sample (head_samples[8*ch+7:8*ch]),
        .gain   (gains[9*ch+8:9*ch]),
        .result (scaled[8*ch+7:8*ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------------

  // pop the fifo only when the output register is free or being drained;
  // gain changes apply from the next sample leaving the fifo
  assign head_ready = clock_enable & (~out_valid | out_ready);

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_luma  <= 8'h00;
      out_u     <= 8'h80;
      out_v     <= 8'h80;
    end else if (head_ready) begin
      out_valid <= head_valid;
      if (head_valid) begin
        out_luma <= scaled[7:0];
        out_u    <= scaled[15:8];
        out_v    <= scaled[23:16];
      end
    end
  end

endmodule

/* testbench/lcgc_checker.sv */
// port assertions of the luma/chroma gain stage
`timescale 1ns/1ps
module lcgc_checker (
  // clock and control
  input wire       clock,
  input wire       reset_n,
  input wire       clock_enable,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_write,
  input wire       reg_read,
  input wire [7:0] reg_rdata,
  // stream
  input wire       in_valid,
  input wire       in_ready,
  input wire       out_valid,
  input wire       out_ready,
  input wire [7:0] out_u,
  input wire [7:0] out_v
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // strobes only count while the stage is enabled
  wire rd = reg_read & clock_enable;
  wire wr = reg_write & clock_enable;
  wire mapped = (reg_addr >= 8'h0B && reg_addr <= 8'h0E) || reg_addr == 8'h1F;
  // write, idle cycle, read of the same place returns the written bits
  property p_rw(a, m);
    wr && reg_addr == a ##1 !wr ##1 rd && reg_addr == a |=> reg_rdata == ($past(reg_wdata, 3) & m);
  endproperty
  a_rdata_idle: assert property (!rd && clock_enable |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_reserved: assert property (rd && reg_addr == 8'h0B |=> !reg_rdata[3])
    else $error("reserved control bit reads one");
  a_ctrl_rw: assert property (p_rw(8'h0B, 8'hF7))
    else $error("control readback wrong");
  a_luma_rw: assert property (p_rw(8'h0C, 8'hFF))
    else $error("luma low readback wrong");
  a_u_rw: assert property (p_rw(8'h0D, 8'hFF))
    else $error("u low readback wrong");
  a_v_rw: assert property (p_rw(8'h0E, 8'hFF))
    else $error("v low readback wrong");
  a_chroma_clip: assert property (out_valid |-> out_u inside {[2:253]} && out_v inside {[2:253]})
    else $error("chroma outside clip range");
  cover property (in_valid && !in_ready);
  cover property (out_valid && out_ready);
  cover property (rd && reg_addr == 8'h0C);
endmodule

/* testbench/luma_chroma_gain_control_tb.sv */
// self-checking bench of the luma/chroma gain stage
`timescale 1ns/1ps
module luma_chroma_gain_control_tb;
  // ----------------------------------------------------------------
  // bench
  // ----------------------------------------------------------------
  reg         reset_n, clock, clock_enable, reg_write, reg_read, in_valid, out_ready, hold;
  reg  [7:0]  reg_addr, reg_wdata, in_luma, in_u, in_v, ctrl;
  wire [7:0]  reg_rdata, out_luma, out_u, out_v;
  wire        in_ready, out_valid;
  reg  [8:0]  lc, uc, vc;
  reg  [23:0] exp_q[$];
  integer     mismatches, checks, i, k, w, taken;
  lcgc_top i_lcgc_top (.clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready), .in_luma(in_luma),
    .in_u(in_u), .in_v(in_v), .out_valid(out_valid), .out_ready(out_ready),
    .out_luma(out_luma), .out_u(out_u), .out_v(out_v));
  // model: round half away from zero, then clip
  function [7:0] f_ch(input integer s, input integer c, input integer un);
    integer p, r;
    begin
      p = (s - 128) * c;
      r = 128 + (p < 0 ? -((un / 2 - p) / un) : (p + un / 2) / un);
      f_ch = r < 2 ? 8'h02 : (r > 253 ? 8'hFD : r);
    end
  endfunction
  function [23:0] f_all(input integer y, input integer u, input integer v);
    integer r;
    begin
      r = (y * lc + 108) / 216;
      f_all = {r > 255 ? 8'hFF : r[7:0], f_ch(u, uc, 254), f_ch(v, vc, 180)};
    end
  endfunction
  task check(input string what, input [23:0] seen, input [23:0] want);
    begin
      checks = checks + 1;
      if (seen !== want) begin
        mismatches = mismatches + 1;
        $display("[ERR] %s expected %h seen %h", what, want, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      @(posedge clock);
    end
  endtask
  task rd(input [7:0] a, input [7:0] want);
    begin
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      // read data stand only in this cycle: look mid-cycle, settled
      @(negedge clock);
      check("reg", reg_rdata, want);
      @(posedge clock);
    end
  endtask
  task wrrd(input [7:0] a, input [7:0] d);
    begin
      wr(a, d);
      rd(a, d);
    end
  endtask
  // read-modify-write keeps the unrelated control bits
  task set_codes(input [8:0] l, input [8:0] u, input [8:0] v);
    begin
      rd(8'h0B, ctrl);
      ctrl = {ctrl[7:4], 1'b0, l[8], u[8], v[8]};
      wrrd(8'h0B, ctrl);
      wrrd(8'h0C, l[7:0]);
      wrrd(8'h0D, u[7:0]);
      wrrd(8'h0E, v[7:0]);
      lc = l;
      uc = u;
      vc = v;
    end
  endtask
  task send(input [7:0] y, input [7:0] u, input [7:0] v);
    begin
      in_valid <= 1'b1;
      in_luma <= y;
      in_u <= u;
      in_v <= v;
      @(posedge clock);
      while (in_ready !== 1'b1) @(posedge clock);
      exp_q.push_back(f_all(y, u, v));
    end
  endtask
  // codes must not move while samples wait in the fifo
  task drain;
    begin
      // own counter: the scenario loop outside uses k
      w = 0;
      while (exp_q.size() != 0 && w < 300) begin
        @(posedge clock);
        w = w + 1;
      end
      check("drain", exp_q.size(), 24'h0);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // sink with random stalls, compared at every accepted sample
  always @(posedge clock) begin
    if (out_valid === 1'b1 && out_ready === 1'b1)
      check("sample", {out_luma, out_u, out_v}, exp_q.size() ? exp_q.pop_front() : 24'h0);
    out_ready <= !hold && ($urandom % 4 != 0);
  end
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #200000;
    mismatches = mismatches + 1;
    tally_and_finish;
  end
  initial begin
    {reset_n, reg_write, reg_read, in_valid, out_ready, hold} = 6'h00;
    {reg_addr, reg_wdata, in_luma, in_u, in_v} = 40'h0;
    clock_enable = 1'b1;
    mismatches = 0;
    checks = 0;
    ctrl = 8'h20;
    lc = 216;
    uc = 254;
    vc = 180;
    i = $urandom(32'hC5FB);
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd(8'h0B, 8'h20);
    rd(8'h0C, 8'hD8);
    rd(8'h0D, 8'hFE);
    rd(8'h0E, 8'hB4);
    rd(8'h05, 8'h00);
    clock_enable <= 1'b0;
    wr(8'h0C, 8'h55);
    clock_enable <= 1'b1;
    rd(8'h0C, 8'hD8);
    // fill at unity gain with the sink stalled until refused
    hold = 1'b1;
    taken = 0;
    @(posedge clock);
    in_valid <= 1'b1;
    for (i = 0; i < 24; i = i + 1) begin
      @(posedge clock);
      if (in_ready === 1'b1) begin
        exp_q.push_back(f_all(in_luma, in_u, in_v));
        taken = taken + 1;
        in_luma <= $urandom;
        in_u <= $urandom;
        in_v <= $urandom;
      end
    end
    in_valid <= 1'b0;
    check("taken", taken, 24'd17);
    hold = 1'b0;
    drain;
    for (k = 0; k < 4; k = k + 1) begin
      case (k)
        0: set_codes(9'h1FF, 9'h1FF, 9'h1FF);
        1: set_codes(9'h000, 9'h000, 9'h000);
        2: set_codes(9'h080, 9'h07F, 9'h05A);
        default: set_codes($urandom, $urandom, $urandom);
      endcase
      send(8'hFF, 8'hFF, 8'h00);
      send(8'h00, 8'h00, 8'hFF);
      for (i = 0; i < 16; i = i + 1) send($urandom, $urandom, $urandom);
      in_valid <= 1'b0;
      drain;
    end
    tally_and_finish;
  end
endmodule
bind lcgc_top lcgc_checker i_lcgc_checker (.clock, .reset_n, .clock_enable, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .in_valid, .in_ready, .out_valid, .out_ready,
  .out_u, .out_v);
